// File: src/misc_control_status_regs.sv
// Misc control and status register bank: pins, front panel, identity, status, selects, resets
// Function
// - Direction bit 0 input, 1 output
// - Value register drives output pins, reads input pins
// - Up hold bit reads live button level
// - Up press latches low, write 1 clears
// - Down hold bit reads live button level
// - Down press latches low, write 1 clears
// - Power press latches low, write 1 clears
// - Power state bit read-write, 1 on
// - Identity: chip rev, board rev, system type
// - Status bit 7 is active-low link input
// - Status bits 6:4 power feeds, rest zero
// - Select bits 5:4 choose serial clock source
// - Select bit 2 parallel DMA, resets 0
// - Select bits 1:0 ISDN DMA, reset 0
// - Reset bits 5:4 lamp outputs, reset 0
// - Bit 3 active-low ISDN reset, cleared
// - Bit 2 active-low EISA reset, cleared
// - Bit 1 active-low keyboard reset, cleared
// - Bit 0 active-low parallel reset, cleared
module misc_control_status_regs #(
  parameter int PIN_COUNT = 8,
  parameter logic [2:0] CHIP_REVISION = 3'h5 // Arbitrary value
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire misc_regs_pkg::reg_req_t reg_req,
  output logic [misc_regs_pkg::DATA_W-1:0] reg_rdata,
  input wire logic [PIN_COUNT-1:0] gp_in,
  output logic [PIN_COUNT-1:0] gp_out,
  output logic [PIN_COUNT-1:0] gp_oe_n,
  input wire misc_regs_pkg::buttons_t buttons,
  output logic up_int_n,
  output logic down_int_n,
  output logic power_int_n,
  output logic power_on,
  input wire logic [3:0] board_revision,
  input wire logic system_type,
  input wire misc_regs_pkg::board_status_t board_status,
  output logic clk_sel_int_10mhz,
  output logic clk_sel_int_6m67,
  output logic clk_sel_external,
  output logic parport_dma_sel,
  output logic [1:0] isdn_dma_sel,
  output logic [1:0] led,
  output misc_regs_pkg::block_resets_t block_resets
);

  function automatic logic hit(input logic [misc_regs_pkg::ADDR_W-1:0] a, input logic [31:0] off);
    hit = (a == off);
  endfunction

  function automatic logic [2:0] clk_decode(input logic [1:0] sel);
    clk_decode = (sel == misc_regs_pkg::CLK_INT_10MHZ) ? 3'h4 :
                 (sel == misc_regs_pkg::CLK_INT_6M67) ? 3'h2 : 3'h1;
  endfunction

  // Register decode; unmapped addresses select nothing
  typedef enum {
    REG_NONE,
    REG_DIRECTION,
    REG_VALUE,
    REG_PANEL,
    REG_IDENTITY,
    REG_STATUS,
    REG_SELECT,
    REG_RESETS
  } reg_index_t;

  function automatic reg_index_t reg_decode(input logic [misc_regs_pkg::ADDR_W-1:0] a);
    if (hit(a, misc_regs_pkg::OFF_PIN_DIRECTION)) begin
      reg_decode = REG_DIRECTION;
    end else if (hit(a, misc_regs_pkg::OFF_PIN_VALUE)) begin
      reg_decode = REG_VALUE;
    end else if (hit(a, misc_regs_pkg::OFF_PANEL_BUTTONS_POWER)) begin
      reg_decode = REG_PANEL;
    end else if (hit(a, misc_regs_pkg::OFF_SYSTEM_IDENTITY)) begin
      reg_decode = REG_IDENTITY;
    end else if (hit(a, misc_regs_pkg::OFF_BOARD_STATUS_INPUTS)) begin
      reg_decode = REG_STATUS;
    end else if (hit(a, misc_regs_pkg::OFF_CLOCK_AND_DMA_SELECT)) begin
      reg_decode = REG_SELECT;
    end else if (hit(a, misc_regs_pkg::OFF_BLOCK_RESET_CONTROL)) begin
      reg_decode = REG_RESETS;
    end else begin
      reg_decode = REG_NONE;
    end
  endfunction

  logic [PIN_COUNT-1:0] pin_direction;
  logic [PIN_COUNT-1:0] pin_value;
  logic [PIN_COUNT-1:0] pin_read;
  logic [1:0] clk_sel;
  logic [2:0] clk_onehot;
  logic [5:0] reset_ctrl;
  logic up_prev;
  logic down_prev;
  logic power_prev;
  logic up_press;
  logic down_press;
  logic power_press;
  logic wr_dir;
  logic wr_val;
  logic wr_pnl;
  logic wr_sel;
  logic wr_rst;
  logic [misc_regs_pkg::DATA_W-1:0] next_rdata;
  logic [misc_regs_pkg::DATA_W-1:0] wd;
  reg_index_t target_reg;
  logic [misc_regs_pkg::DATA_W-1:0] rd_direction;
  logic [misc_regs_pkg::DATA_W-1:0] rd_value;
  logic [misc_regs_pkg::DATA_W-1:0] rd_panel;
  logic [misc_regs_pkg::DATA_W-1:0] rd_identity;
  logic [misc_regs_pkg::DATA_W-1:0] rd_status;
  logic [misc_regs_pkg::DATA_W-1:0] rd_select;
  logic [misc_regs_pkg::DATA_W-1:0] rd_resets;

  assign wd = reg_req.wdata;
  assign target_reg = reg_decode(reg_req.addr);
  assign wr_dir = reg_req.wr && (target_reg == REG_DIRECTION);
  assign wr_val = reg_req.wr && (target_reg == REG_VALUE);
  assign wr_pnl = reg_req.wr && (target_reg == REG_PANEL);
  assign wr_sel = reg_req.wr && (target_reg == REG_SELECT);
  assign wr_rst = reg_req.wr && (target_reg == REG_RESETS);

  // General purpose pins
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pin_direction <= PIN_COUNT'(misc_regs_pkg::PIN_DIRECTION_RESET);
    end else if (wr_dir) begin
      pin_direction <= wd[PIN_COUNT-1:0];
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pin_value <= PIN_COUNT'(misc_regs_pkg::PIN_VALUE_RESET);
    end else if (wr_val) begin
      // Stored even for input bits so a later turn to output drives the written level
      pin_value <= wd[PIN_COUNT-1:0];
    end
  end

  genvar g;
  generate
    for (g = 0; g < PIN_COUNT; g++) begin : gen_pin
      assign gp_out[g] = pin_value[g];
      assign gp_oe_n[g] = ~pin_direction[g];
      assign pin_read[g] = pin_direction[g] ? pin_value[g] : gp_in[g];
    end
  endgenerate

  // Button press edges; idle level is released (high)
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      up_prev <= 1'b1;
      down_prev <= 1'b1;
      power_prev <= 1'b1;
    end else begin
      up_prev <= buttons.up_n;
      down_prev <= buttons.down_n;
      power_prev <= buttons.power_n;
    end
  end

  assign up_press = up_prev && !buttons.up_n;
  assign down_press = down_prev && !buttons.down_n;
  assign power_press = power_prev && !buttons.power_n;

  // Latched panel interrupts, active low; a press in the clearing cycle wins
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      up_int_n <= 1'b1;
    end else if (up_press) begin
      up_int_n <= 1'b0;
    end else if (wr_pnl && wd[misc_regs_pkg::PNL_UP_INT]) begin
      up_int_n <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      down_int_n <= 1'b1;
    end else if (down_press) begin
      down_int_n <= 1'b0;
    end else if (wr_pnl && wd[misc_regs_pkg::PNL_DOWN_INT]) begin
      down_int_n <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      power_int_n <= 1'b1;
    end else if (power_press) begin
      power_int_n <= 1'b0;
    end else if (wr_pnl && wd[misc_regs_pkg::PNL_POWER_INT]) begin
      power_int_n <= 1'b1;
    end
  end

  // Resets to on so a reset does not drop the supply
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      power_on <= misc_regs_pkg::POWER_STATE_RESET;
    end else if (wr_pnl) begin
      power_on <= wd[misc_regs_pkg::PNL_POWER_STATE];
    end
  end

  // Clock and DMA selects
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      clk_sel <= misc_regs_pkg::CLK_SEL_RESET;
    end else if (wr_sel) begin
      clk_sel <= wd[misc_regs_pkg::SEL_CLK_LSB +: 2];
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      parport_dma_sel <= misc_regs_pkg::DMA_SEL_RESET[misc_regs_pkg::SEL_PAR_DMA];
    end else if (wr_sel) begin
      parport_dma_sel <= wd[misc_regs_pkg::SEL_PAR_DMA];
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      isdn_dma_sel <= misc_regs_pkg::DMA_SEL_RESET[1:0];
    end else if (wr_sel) begin
      isdn_dma_sel <= {wd[misc_regs_pkg::SEL_ISDN1], wd[misc_regs_pkg::SEL_ISDN0]};
    end
  end

  assign clk_onehot = clk_decode(clk_sel);
  assign clk_sel_int_10mhz = clk_onehot[2];
  assign clk_sel_int_6m67 = clk_onehot[1];
  assign clk_sel_external = clk_onehot[0];

  // Block resets and lamps, all cleared so neighbours stay held until software releases them
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      reset_ctrl <= misc_regs_pkg::RESET_CTRL_RESET;
    end else if (wr_rst) begin
      reset_ctrl <= wd[5:0];
    end
  end

  assign led = reset_ctrl[misc_regs_pkg::RST_LED_LSB +: 2];
  assign block_resets.isdn_n = reset_ctrl[misc_regs_pkg::RST_ISDN];
  assign block_resets.eisa_n = reset_ctrl[misc_regs_pkg::RST_EISA];
  assign block_resets.kbd_n = reset_ctrl[misc_regs_pkg::RST_KBD];
  assign block_resets.par_n = reset_ctrl[misc_regs_pkg::RST_PAR];

  // Per-register read words; unused bits stay zero
  always_comb begin
    rd_direction = 8'h00;
    rd_direction[PIN_COUNT-1:0] = pin_direction;
  end

  always_comb begin
    rd_value = 8'h00;
    rd_value[PIN_COUNT-1:0] = pin_read;
  end

  always_comb begin
    rd_panel = 8'h00;
    rd_panel[misc_regs_pkg::PNL_UP_HOLD] = buttons.up_n;
    rd_panel[misc_regs_pkg::PNL_UP_INT] = up_int_n;
    rd_panel[misc_regs_pkg::PNL_DOWN_HOLD] = buttons.down_n;
    rd_panel[misc_regs_pkg::PNL_DOWN_INT] = down_int_n;
    rd_panel[misc_regs_pkg::PNL_POWER_INT] = power_int_n;
    rd_panel[misc_regs_pkg::PNL_POWER_STATE] = power_on;
  end

  always_comb begin
    rd_identity = 8'h00;
    rd_identity[misc_regs_pkg::ID_CHIP_LSB +: 3] = CHIP_REVISION;
    rd_identity[misc_regs_pkg::ID_BOARD_LSB +: 4] = board_revision;
    rd_identity[misc_regs_pkg::ID_TYPE_BIT] = system_type;
  end

  always_comb begin
    rd_status = 8'h00;
    rd_status[misc_regs_pkg::ST_LINK_N] = board_status.link_n;
    rd_status[misc_regs_pkg::ST_NET_POWER] = board_status.net_power;
    rd_status[misc_regs_pkg::ST_STORE1_POWER] = board_status.store1_power;
    rd_status[misc_regs_pkg::ST_STORE0_POWER] = board_status.store0_power;
  end

  always_comb begin
    rd_select = 8'h00;
    rd_select[misc_regs_pkg::SEL_CLK_LSB +: 2] = clk_sel;
    rd_select[misc_regs_pkg::SEL_PAR_DMA] = parport_dma_sel;
    rd_select[misc_regs_pkg::SEL_ISDN1] = isdn_dma_sel[1];
    rd_select[misc_regs_pkg::SEL_ISDN0] = isdn_dma_sel[0];
  end

  always_comb begin
    rd_resets = 8'h00;
    rd_resets[5:0] = reset_ctrl;
  end

  // One word per access; the address map lives in reg_decode only
  always_comb begin
    case (target_reg)
      REG_DIRECTION: begin
        next_rdata = rd_direction;
      end
      REG_VALUE: begin
        next_rdata = rd_value;
      end
      REG_PANEL: begin
        next_rdata = rd_panel;
      end
      REG_IDENTITY: begin
        next_rdata = rd_identity;
      end
      REG_STATUS: begin
        next_rdata = rd_status;
      end
      REG_SELECT: begin
        next_rdata = rd_select;
      end
      REG_RESETS: begin
        next_rdata = rd_resets;
      end
      default: begin
        next_rdata = 8'h00;
      end
    endcase
  end

  // Data only meaningful the cycle after a read strobe; zero otherwise
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_req.rd) begin
      reg_rdata <= next_rdata;
    end else begin
      reg_rdata <= 8'h00;
    end
  end

endmodule // misc_control_status_regs

// File: src/misc_regs_pkg.sv
// Package: offsets, field layout, reset values and carrier types of the misc register bank
package misc_regs_pkg;

  localparam int ADDR_W = 32;
  localparam int DATA_W = 8;

  // Register byte addresses
  localparam logic [31:0] OFF_PIN_DIRECTION = 32'h1FBD9848;
  localparam logic [31:0] OFF_PIN_VALUE = 32'h1FBD984C;
  localparam logic [31:0] OFF_PANEL_BUTTONS_POWER = 32'h1FBD9850;
  localparam logic [31:0] OFF_SYSTEM_IDENTITY = 32'h1FBD9858;
  localparam logic [31:0] OFF_BOARD_STATUS_INPUTS = 32'h1FBD9860;
  localparam logic [31:0] OFF_CLOCK_AND_DMA_SELECT = 32'h1FBD9868;
  localparam logic [31:0] OFF_BLOCK_RESET_CONTROL = 32'h1FBD9870;

  // Front panel fields
  localparam int PNL_UP_HOLD = 7;
  localparam int PNL_UP_INT = 6;
  localparam int PNL_DOWN_HOLD = 5;
  localparam int PNL_DOWN_INT = 4;
  localparam int PNL_POWER_INT = 1;
  localparam int PNL_POWER_STATE = 0;

  // Identity fields
  localparam int ID_CHIP_LSB = 5;
  localparam int ID_BOARD_LSB = 1;
  localparam int ID_TYPE_BIT = 0;

  // Status fields
  localparam int ST_LINK_N = 7;
  localparam int ST_NET_POWER = 6;
  localparam int ST_STORE1_POWER = 5;
  localparam int ST_STORE0_POWER = 4;

  // Select fields
  localparam int SEL_CLK_LSB = 4;
  localparam int SEL_PAR_DMA = 2;
  localparam int SEL_ISDN1 = 1;
  localparam int SEL_ISDN0 = 0;

  // Reset register fields
  localparam int RST_LED_LSB = 4;
  localparam int RST_ISDN = 3;
  localparam int RST_EISA = 2;
  localparam int RST_KBD = 1;
  localparam int RST_PAR = 0;

  // Reset values
  localparam logic [7:0] PIN_DIRECTION_RESET = 8'h00;
  localparam logic [7:0] PIN_VALUE_RESET = 8'h00;
  localparam logic POWER_STATE_RESET = 1'b1;
  localparam logic [1:0] CLK_SEL_RESET = 2'h0;
  localparam logic [2:0] DMA_SEL_RESET = 3'h0;
  localparam logic [5:0] RESET_CTRL_RESET = 6'h00;

  // Serial clock source codes
  localparam logic [1:0] CLK_INT_10MHZ = 2'h0;
  localparam logic [1:0] CLK_INT_6M67 = 2'h1;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  typedef struct packed {
    logic up_n;
    logic down_n;
    logic power_n;
  } buttons_t;

  typedef struct packed {
    logic link_n;
    logic net_power;
    logic store1_power;
    logic store0_power;
  } board_status_t;

  typedef struct packed {
    logic isdn_n;
    logic eisa_n;
    logic kbd_n;
    logic par_n;
  } block_resets_t;

endpackage

// File: bench/misc_regs_chk.sv
// Checker: port-level assertions for the misc register bank
module misc_regs_chk #(
  parameter int PIN_COUNT = 8,
  parameter logic [2:0] CHIP_REVISION = 3'h5
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire misc_regs_pkg::reg_req_t reg_req,
  input wire logic [misc_regs_pkg::DATA_W-1:0] reg_rdata,
  input wire logic [PIN_COUNT-1:0] gp_oe_n,
  input wire misc_regs_pkg::buttons_t buttons,
  input wire logic up_int_n,
  input wire logic power_int_n,
  input wire logic down_int_n,
  input wire logic [3:0] board_revision,
  input wire logic system_type,
  input wire misc_regs_pkg::board_status_t board_status,
  input wire logic clk_sel_int_6m67,
  input wire logic clk_sel_external,
  input wire logic [1:0] led,
  input wire misc_regs_pkg::block_resets_t block_resets
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] PNL = misc_regs_pkg::OFF_PANEL_BUTTONS_POWER;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence s_wr(logic [31:0] a);
    reg_req.wr && reg_req.addr == a;
  endsequence
  sequence s_rd(logic [31:0] a);
    reg_req.rd && reg_req.addr == a;
  endsequence
  property p_dir;
    s_wr(misc_regs_pkg::OFF_PIN_DIRECTION) |=> gp_oe_n == ~$past(reg_req.wdata);
  endproperty
  property p_up;
    $fell(buttons.up_n) |=> !up_int_n;
  endproperty
  property p_down;
    $fell(buttons.down_n) |=> !down_int_n;
  endproperty
  property p_pwr;
    $fell(buttons.power_n) |=> !power_int_n;
  endproperty
  // Writing 0 must not clear a pending latch
  property p_keep;
    s_wr(PNL) ##0 (!reg_req.wdata[4] && !down_int_n) |=> !down_int_n;
  endproperty
  property p_id;
    s_rd(misc_regs_pkg::OFF_SYSTEM_IDENTITY) |=>
      reg_rdata == {CHIP_REVISION, $past(board_revision), $past(system_type)};
  endproperty
  property p_st;
    s_rd(misc_regs_pkg::OFF_BOARD_STATUS_INPUTS) |=> reg_rdata == {$past(board_status), 4'h0};
  endproperty
  property p_clk;
    s_wr(misc_regs_pkg::OFF_CLOCK_AND_DMA_SELECT) |=> clk_sel_external == $past(reg_req.wdata[5])
      && clk_sel_int_6m67 == ($past(reg_req.wdata[5:4]) == 2'h1);
  endproperty
  property p_rst;
    s_wr(misc_regs_pkg::OFF_BLOCK_RESET_CONTROL) |=> {led, block_resets} == $past(reg_req.wdata[5:0]);
  endproperty
  a_dir: assert property (p_dir) else $error("direction write not on enables");
  a_up: assert property (p_up) else $error("up press not latched");
  a_down: assert property (p_down) else $error("down press not latched");
  a_pwr: assert property (p_pwr) else $error("power press not latched");
  a_keep: assert property (p_keep) else $error("latch lost on zero write");
  a_id: assert property (p_id) else $error("identity read wrong");
  a_st: assert property (p_st) else $error("status read wrong");
  a_clk: assert property (p_clk) else $error("clock select decode wrong");
  a_rst: assert property (p_rst) else $error("reset outputs wrong");
endmodule // misc_regs_chk

bind misc_control_status_regs misc_regs_chk #(.PIN_COUNT(PIN_COUNT), .CHIP_REVISION(CHIP_REVISION)) u_misc_regs_chk (
  .sys_clk, .rst, .reg_req, .reg_rdata, .gp_oe_n, .buttons, .up_int_n, .power_int_n, .down_int_n,
  .board_revision, .system_type, .board_status, .clk_sel_int_6m67, .clk_sel_external, .led, .block_resets);

// File: bench/far_side_model.sv
// Far-side model: panel buttons and the general-purpose pin wires
module far_side_model (
  input wire logic [2:0] press,
  input wire logic [7:0] pin_drive,
  input wire logic [7:0] gp_out,
  input wire logic [7:0] gp_oe_n,
  output misc_regs_pkg::buttons_t buttons,
  output logic [7:0] gp_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // Switches to ground: held reads 0
  assign buttons = ~press;
  // Bank wins where it drives, outside level elsewhere
  assign gp_in = (gp_out & ~gp_oe_n) | (pin_drive & gp_oe_n);
endmodule // far_side_model

// File: bench/misc_control_status_regs_test.sv
// Testbench: register access sequences for the misc register bank
module misc_control_status_regs_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] DIR = misc_regs_pkg::OFF_PIN_DIRECTION;
  localparam logic [31:0] VAL = misc_regs_pkg::OFF_PIN_VALUE;
  localparam logic [31:0] PNL = misc_regs_pkg::OFF_PANEL_BUTTONS_POWER;
  localparam logic [31:0] SEL = misc_regs_pkg::OFF_CLOCK_AND_DMA_SELECT;
  localparam logic [31:0] RST = misc_regs_pkg::OFF_BLOCK_RESET_CONTROL;
  logic sys_clk, rst, system_type, up_int_n, down_int_n, power_int_n, power_on;
  logic sel10, sel667, selext, parport_dma_sel;
  logic [1:0] isdn_dma_sel, led;
  logic [2:0] press;
  logic [3:0] board_revision;
  logic [7:0] reg_rdata, gp_in, gp_out, gp_oe_n, pin_drive;
  logic [7:0] int_m [3] = '{8'h02, 8'h10, 8'h40};
  logic [7:0] hold_m [3] = '{8'h00, 8'h20, 8'h80};
  logic [7:0] d;
  misc_regs_pkg::reg_req_t reg_req;
  misc_regs_pkg::buttons_t buttons;
  misc_regs_pkg::board_status_t board_status;
  misc_regs_pkg::block_resets_t block_resets;
  int num_errors = 0;
  int comparisons = 0;

  misc_control_status_regs u_misc_control_status_regs (.sys_clk, .rst, .reg_req, .reg_rdata, .gp_in,
    .gp_out, .gp_oe_n, .buttons, .up_int_n, .down_int_n, .power_int_n, .power_on, .board_revision,
    .system_type, .board_status, .clk_sel_int_10mhz(sel10), .clk_sel_int_6m67(sel667),
    .clk_sel_external(selext), .parport_dma_sel, .isdn_dma_sel, .led, .block_resets);
  far_side_model u_far_side_model (.press, .pin_drive, .gp_out, .gp_oe_n, .buttons, .gp_in);

  task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    reg_req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk);
    reg_req.wr <= 1'b0;
    #1;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [31:0] a, input logic [7:0] exp, input string name);
    @(posedge sys_clk);
    reg_req.addr <= a;
    reg_req.rd <= 1'b1;
    @(posedge sys_clk);
    reg_req.rd <= 1'b0;
    #1;
    check(name, exp, reg_rdata);
  endtask
  task automatic end_of_test();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  initial begin
    repeat (5000) @(posedge sys_clk);
    num_errors++;
    end_of_test();
  end
  initial begin
    rst = 1'b1;
    reg_req = '0;
    press = 3'h0;
    pin_drive = 8'hC3;
    board_revision = 4'h9;
    system_type = 1'b1;
    board_status = 4'hA;
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    rd(DIR, 8'h00, "dir");
    rd(VAL, 8'hC3, "pins in");
    rd(PNL, 8'hF3, "panel");
    rd(misc_regs_pkg::OFF_SYSTEM_IDENTITY, {3'h5, 4'h9, 1'b1}, "id");
    check("resets", 8'h00, {2'h0, led, block_resets});
    rd(SEL, 8'h00, "select reset");
    check("clk reset", 8'h04, {5'h0, sel10, sel667, selext});
    check("oe_n reset", 8'hFF, gp_oe_n);
    check("out reset", 8'h00, gp_out);
    wr(DIR, 8'hFF);
    wr(VAL, 8'hFF);
    check("oe_n", 8'h00, gp_oe_n);
    check("out", 8'hFF, gp_out);
    wr(DIR, 8'h0F);
    wr(VAL, 8'h5A);
    rd(VAL, 8'hCA, "pins mixed");
    for (int i = 0; i < 3; i++) begin
      @(posedge sys_clk) press <= 3'h1 << i;
      rd(PNL, 8'hF3 & ~hold_m[i] & ~int_m[i], "held");
      @(posedge sys_clk) press <= 3'h0;
      wr(PNL, 8'h01);
      rd(PNL, 8'hF3 & ~int_m[i], "latched");
      wr(PNL, int_m[i] | 8'h01);
      rd(PNL, 8'hF3, "cleared");
    end
    wr(PNL, 8'h00);
    check("power", 8'h00, {7'h0, power_on});
    for (int i = 0; i < 16; i += 5) begin
      @(posedge sys_clk) board_status <= 4'(i);
      rd(misc_regs_pkg::OFF_BOARD_STATUS_INPUTS, {4'(i), 4'h0}, "status");
    end
    for (int c = 0; c < 4; c++) begin
      d = {2'h3, 2'(c), 1'b1, 3'(c + 1)};
      wr(SEL, d);
      rd(SEL, d & 8'h37, "select");
      check("clk sel", {5'h0, c == 0, c == 1, c > 1}, {5'h0, sel10, sel667, selext});
      check("dma", {5'h0, d[2:0]}, {5'h0, parport_dma_sel, isdn_dma_sel});
    end
    wr(RST, 8'hFF);
    rd(RST, 8'h3F, "reset reg");
    wr(RST, 8'h05);
    check("resets", 8'h05, {2'h0, led, block_resets});
    wr(32'h1FBD9854, 8'hFF);
    rd(32'h1FBD9854, 8'h00, "unmapped");
    wr(misc_regs_pkg::OFF_SYSTEM_IDENTITY, 8'h00);
    rd(misc_regs_pkg::OFF_SYSTEM_IDENTITY, {3'h5, 4'h9, 1'b1}, "id ro");
    end_of_test();
  end
endmodule // misc_control_status_regs_test
